// file: common/pbsp_pkg.sv
// Purpose: shared constants and types of the pipelined burst sram port
// Assumes: single clock CORE_CLK at 10 MHz, synchronous active-high reset
// Notes:   the x36 organisation is built; the x18 figures are kept for reference
package pbsp_pkg;

   // array organisation
   localparam int ADDR_W        = 18;
   localparam int DATA_W        = 36;
   localparam int LANE_N        = 4;
   localparam int LANE_W        = 9;
   localparam int MEM_WORDS     = 262144;
   localparam int NARROW_WORDS  = 524288;
   localparam int NARROW_DATA_W = 18;

   // burst counter
   localparam int BURST_W   = 2;
   localparam int BURST_LEN = 4;
   localparam int PIPE_LAT  = 2;

   // write commit buffer
   localparam int FIFO_DEPTH = 4;
   localparam int ENTRY_W    = ADDR_W + LANE_N + DATA_W;

   // entry field positions
   localparam int ENT_DATA_LO = 0;
   localparam int ENT_LANE_LO = DATA_W;
   localparam int ENT_ADDR_LO = DATA_W + LANE_N;

   // timing
   localparam int CLK_PERIOD_NS = 100;

   // values after reset
   localparam logic              RST_OE_N    = 1'h1;
   localparam logic [DATA_W-1:0] RST_DATA    = 36'h0;
   localparam logic [BURST_W-1:0] RST_STEP   = 2'h0;
   localparam logic              RST_STALLED = 1'h0;

   typedef logic [ADDR_W-1:0]  pbsp_addr_t;
   typedef logic [DATA_W-1:0]  pbsp_data_t;
   typedef logic [LANE_N-1:0]  pbsp_lane_t;
   typedef logic [BURST_W-1:0] pbsp_ofs_t;

   typedef enum logic {
      PBSP_LINEAR,
      PBSP_INTERLEAVED
   } pbsp_order_e;

endpackage : pbsp_pkg

// file: common/pbsp_fifo_if.sv
// Purpose: valid/ready carrier between the port core and its write buffer
// Assumes: one clock, both sides sample on the same edge
// Notes:   a word moves on an edge where valid and ready are both high
`timescale 1ns/1ps
interface pbsp_fifo_if #(
   parameter int W = 8
);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;

   modport filler  (output in_valid, output in_data, input in_ready,
                    input out_valid, input out_data, output out_ready);
   modport buffer  (input in_valid, input in_data, output in_ready,
                    output out_valid, output out_data, input out_ready);
endinterface : pbsp_fifo_if

// file: src/pbsp_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: synchronous active-high reset
// Notes:   full and empty come from a registered count, no fall-through
`timescale 1ns/1ps
module pbsp_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 4
) (
   input wire logic   clk,
   input wire logic   rst,
   pbsp_fifo_if.buffer fb
);
   localparam int PW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0]   count;
   logic          push;
   logic          pop;

   // count is one bit wider than the pointers so that full and empty differ
   assign fb.in_ready  = (count != (PW+1)'(DEPTH));
   assign fb.out_valid = (count != '0);
   assign fb.out_data  = mem[rd_ptr];
   assign push         = fb.in_valid && fb.in_ready;
   assign pop          = fb.out_valid && fb.out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= fb.in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'h1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'h1;
         end
         count <= count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

endmodule : pbsp_fifo

// file: src/pbsp_sram_port.sv
// Purpose: pipelined burst sram port, data two cycles after address
// Assumes: inputs synchronous to CORE_CLK except the three noted below
// Notes:   writes pass a 4-word commit buffer before reaching the array
//
// Summary of operation
// [RULE1] register every synchronous input on rising edge
// [RULE2] data moves two cycles after address/control
// [RULE3] read and write alternate with no idle cycle
// [RULE4] suspend high freezes inputs and all state; the commit buffer, synchronisers, draining and PORT_STALLED keep running
// [RULE5] deselect with load starts nothing, ends burst
// [RULE6] deselect still finishes transfers in flight
// [RULE7] bus released two cycles after deselect/write
// [RULE8] two-bit counter gives four words per address
// [RULE9] order input picks linear or interleaved burst
// [RULE10] load low loads address, high advances counter
// [RULE11] output disable forces bus off asynchronously
// [RULE12] sleep and order inputs asynchronous; sleep tie low
// [RULE13] per-lane write enables; all low writes word
// [RULE14] array is 262144 x 36 (x18 option 524288)
// [RULE15] nine-bit lane enables valid on write cycles only
// [RULE16] two low address bits seed burst counter
// [RULE17] write select on load fixes whole burst direction
// [RULE18] linear adds step mod four; interleaved xors step
// [RULE19] bus driven only in pipelined read data cycles
`timescale 1ns/1ps
module pbsp_sram_port (
   input  wire logic                         CORE_CLK,
   input  wire logic                         RST,
   input  wire logic [pbsp_pkg::ADDR_W-1:0]  ADDR,
   input  wire logic                         CHIP_SELECT_A_N,
   input  wire logic                         CHIP_SELECT_B,
   input  wire logic                         CHIP_SELECT_C_N,
   input  wire logic                         LOAD_OR_ADVANCE,
   input  wire logic                         CYCLE_SUSPEND_N,
   input  wire logic                         WRITE_SELECT_N,
   input  wire logic [pbsp_pkg::LANE_N-1:0]  LANE_WRITE_N,
   input  wire logic                         BURST_ORDER,
   input  wire logic                         OUTPUT_DISABLE_N,
   input  wire logic                         SLEEP_REQUEST,
   input  wire logic [pbsp_pkg::DATA_W-1:0]  DATA_IN,
   output logic      [pbsp_pkg::DATA_W-1:0]  DATA_OUT,
   output logic                              DATA_OE_N,
   output logic                              PORT_STALLED
);

   // array, one word per address
   pbsp_pkg::pbsp_data_t mem [pbsp_pkg::MEM_WORDS]; // see [RULE14]

   // asynchronous inputs, two-flop synchronisers
   logic                  sleep_meta;
   logic                  sleep_sync;
   logic                  order_meta;
   logic                  order_sync;
   pbsp_pkg::pbsp_order_e order;

   // stage one: registered request
   logic                  s1_valid;
   logic                  s1_write;
   pbsp_pkg::pbsp_addr_t  s1_addr;
   pbsp_pkg::pbsp_lane_t  s1_lanes_n;

   // stage two: request one cycle older
   logic                  s2_valid;
   logic                  s2_write;
   pbsp_pkg::pbsp_addr_t  s2_addr;
   pbsp_pkg::pbsp_lane_t  s2_lanes_n;

   // burst state
   logic                  burst_active;
   logic                  burst_write;
   pbsp_pkg::pbsp_addr_t  burst_base;
   pbsp_pkg::pbsp_ofs_t   burst_start;
   pbsp_pkg::pbsp_ofs_t   burst_step;

   // next values of stage one
   logic                  next_s1_valid;
   logic                  next_s1_write;
   pbsp_pkg::pbsp_addr_t  next_s1_addr;
   pbsp_pkg::pbsp_ofs_t   next_step;
   pbsp_pkg::pbsp_ofs_t   next_offset;

   logic                  selected;
   logic                  loading;
   logic                  hold;
   logic                  push_stall;
   logic                  read_stall;
   logic                  draining;
   logic                  rd_issue;
   logic                  next_oe_n;
   pbsp_pkg::pbsp_data_t  read_word;

   // head of the commit buffer
   pbsp_pkg::pbsp_addr_t  head_addr;
   pbsp_pkg::pbsp_lane_t  head_lanes_n;
   pbsp_pkg::pbsp_data_t  head_data;

   pbsp_fifo_if #(.W(pbsp_pkg::ENTRY_W)) wbuf ();

   pbsp_fifo #(
      .W     (pbsp_pkg::ENTRY_W),
      .DEPTH (pbsp_pkg::FIFO_DEPTH)
   ) u_wbuf (
      .clk (CORE_CLK),
      .rst (RST),
      .fb  (wbuf)
   );

   // sleep changes at any time; only the second flop is looked at
   always_ff @(posedge CORE_CLK) begin
      sleep_meta <= SLEEP_REQUEST; // see [RULE12]
      sleep_sync <= sleep_meta;
   end

   // order may move at any time; a change lands two or three edges later
   always_ff @(posedge CORE_CLK) begin
      order_meta <= BURST_ORDER; // see [RULE12]
      order_sync <= order_meta;
   end

   assign order = order_sync ? pbsp_pkg::PBSP_INTERLEAVED : pbsp_pkg::PBSP_LINEAR; // see [RULE9]

   // any one select false on a load makes a deselect cycle
   assign selected = !CHIP_SELECT_A_N && CHIP_SELECT_B && !CHIP_SELECT_C_N;
   assign loading  = !LOAD_OR_ADVANCE; // see [RULE10]

   // a full buffer or a read that would miss buffered writes freezes the port
   assign push_stall = s2_valid && s2_write && !wbuf.in_ready;
   assign rd_issue   = s2_valid && !s2_write;
   assign read_stall = rd_issue && (sleep_sync || draining);
   assign hold       = CYCLE_SUSPEND_N || push_stall || read_stall; // see [RULE4]

   // burst offset for an advance cycle
   always_comb begin
      next_step = burst_step + 2'h1;
      unique case (order)
         pbsp_pkg::PBSP_LINEAR:      next_offset = burst_start + next_step; // see [RULE18]
         pbsp_pkg::PBSP_INTERLEAVED: next_offset = burst_start ^ next_step; // see [RULE18]
      endcase
   end

   // request decode for stage one
   always_comb begin
      next_s1_valid = 1'h0;
      next_s1_write = s1_write;
      next_s1_addr  = s1_addr;
      if (loading) begin
         if (selected) begin // see [RULE5]
            next_s1_valid = 1'h1;
            next_s1_write = !WRITE_SELECT_N; // see [RULE17]
            next_s1_addr  = ADDR;
         end
      end else if (burst_active) begin // see [RULE8]
         next_s1_valid = 1'h1;
         next_s1_write = burst_write; // see [RULE17]
         next_s1_addr  = {burst_base[pbsp_pkg::ADDR_W-1:pbsp_pkg::BURST_W], next_offset};
      end
   end

   // burst state, fixed by the load cycle for the whole burst
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         burst_active <= 1'h0;
         burst_write  <= 1'h0;
         burst_base   <= '0;
         burst_start  <= pbsp_pkg::RST_STEP;
      end else if (!hold) begin
         if (loading) begin
            burst_active <= selected; // see [RULE5]
            if (selected) begin
               burst_write <= !WRITE_SELECT_N;
               burst_base  <= ADDR;
               burst_start <= ADDR[pbsp_pkg::BURST_W-1:0]; // see [RULE16]
            end
         end
      end
   end

   // step counter; two bits, so a fifth beat wraps back to the start
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         burst_step <= pbsp_pkg::RST_STEP;
      end else if (!hold) begin
         if (loading && selected) begin
            burst_step <= pbsp_pkg::RST_STEP;
         end else if (!loading && burst_active) begin
            burst_step <= next_step; // see [RULE8]
         end
      end
   end

   // input capture, stage one
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         s1_valid   <= 1'h0;
         s1_write   <= 1'h0;
         s1_addr    <= '0;
         s1_lanes_n <= '1;
      end else if (!hold) begin // see [RULE1]
         s1_valid   <= next_s1_valid;
         s1_write   <= next_s1_write;
         s1_addr    <= next_s1_addr;
         s1_lanes_n <= LANE_WRITE_N; // see [RULE15]
      end
   end

   // stage two; a deselect empties stage one but never this stage
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         s2_valid   <= 1'h0;
         s2_write   <= 1'h0;
         s2_addr    <= '0;
         s2_lanes_n <= '1;
      end else if (!hold) begin // see [RULE6]
         s2_valid   <= s1_valid;
         s2_write   <= s1_write;
         s2_addr    <= s1_addr;
         s2_lanes_n <= s1_lanes_n;
      end
   end

   // write data taken two cycles after its address
   assign wbuf.in_valid = s2_valid && s2_write && !hold; // see [RULE2]
   assign wbuf.in_data  = {s2_addr, s2_lanes_n, DATA_IN};

   // the array sleeps, so buffered writes wait and the buffer can fill
   assign wbuf.out_ready = !sleep_sync;
   assign head_addr      = wbuf.out_data[pbsp_pkg::ENT_ADDR_LO +: pbsp_pkg::ADDR_W];
   assign head_lanes_n   = wbuf.out_data[pbsp_pkg::ENT_LANE_LO +: pbsp_pkg::LANE_N];
   assign head_data      = wbuf.out_data[pbsp_pkg::ENT_DATA_LO +: pbsp_pkg::DATA_W];

   // commit one buffered word per cycle, low lane enable writes that lane
   always_ff @(posedge CORE_CLK) begin
      if (wbuf.out_valid && wbuf.out_ready) begin
         for (int i = 0; i < pbsp_pkg::LANE_N; i++) begin
            if (!head_lanes_n[i]) begin // see [RULE13]
               mem[head_addr][i*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W] <=
                  head_data[i*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W];
            end
         end
      end
   end

   // after sleep, reads wait until the backlog is gone
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         draining <= 1'h0;
      end else if (sleep_sync) begin
         draining <= 1'h1;
      end else if (!wbuf.out_valid) begin
         draining <= 1'h0;
      end
   end

   // read forwards the word being committed on the same edge
   always_comb begin
      read_word = mem[s2_addr];
      if (wbuf.out_valid && head_addr == s2_addr) begin // see [RULE3]
         for (int i = 0; i < pbsp_pkg::LANE_N; i++) begin
            if (!head_lanes_n[i]) begin
               read_word[i*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W] =
                  head_data[i*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W];
            end
         end
      end
   end

   // read data register, unchanged while frozen
   // holding the last word between reads keeps the output quiet
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         DATA_OUT <= pbsp_pkg::RST_DATA;
      end else if (!hold && rd_issue) begin // see [RULE2]
         DATA_OUT <= read_word;
      end
   end

   // bus drives only for read data leaving stage two
   assign next_oe_n = !rd_issue; // see [RULE19]

   // bus enable: async disable wins over everything, clock or not
   always_ff @(posedge CORE_CLK or negedge OUTPUT_DISABLE_N) begin
      if (!OUTPUT_DISABLE_N) begin
         DATA_OE_N <= pbsp_pkg::RST_OE_N; // see [RULE11]
      end else if (RST) begin
         DATA_OE_N <= pbsp_pkg::RST_OE_N;
      end else if (!hold) begin
         DATA_OE_N <= next_oe_n; // see [RULE7] see [RULE19]
      end
   end

   // stall indicator, one cycle behind a buffer or read stall; a suspend freeze does not raise it
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         PORT_STALLED <= pbsp_pkg::RST_STALLED;
      end else begin
         PORT_STALLED <= push_stall || read_stall;
      end
   end

endmodule : pbsp_sram_port

// file: tb/pbsp_sram_port_asserts.sv
// Purpose: timing checks on the port pins
// Assumes: sleep low; freezes come only from suspend
// Notes:   answers are judged at the sample after edge k+2
`timescale 1ns/1ps
module pbsp_sram_port_asserts (
   input wire logic                        CORE_CLK,
   input wire logic                        RST,
   input wire logic [pbsp_pkg::ADDR_W-1:0] ADDR,
   input wire logic                        CHIP_SELECT_A_N,
   input wire logic                        CHIP_SELECT_B,
   input wire logic                        CHIP_SELECT_C_N,
   input wire logic                        LOAD_OR_ADVANCE,
   input wire logic                        CYCLE_SUSPEND_N,
   input wire logic                        WRITE_SELECT_N,
   input wire logic [pbsp_pkg::LANE_N-1:0] LANE_WRITE_N,
   input wire logic                        OUTPUT_DISABLE_N,
   input wire logic                        SLEEP_REQUEST,
   input wire logic [pbsp_pkg::DATA_W-1:0] DATA_OUT,
   input wire logic                        DATA_OE_N,
   input wire logic                        PORT_STALLED
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   wire run   = !CYCLE_SUSPEND_N && !SLEEP_REQUEST;
   wire sel   = !CHIP_SELECT_A_N && CHIP_SELECT_B && !CHIP_SELECT_C_N;
   wire rd_ld = run && sel && !LOAD_OR_ADVANCE && WRITE_SELECT_N;
   wire wr_ld = run && sel && !LOAD_OR_ADVANCE && !WRITE_SELECT_N;
   wire desel = run && !sel && !LOAD_OR_ADVANCE;
   // forced off counts as allowed, the async path wins
   wire on_ok = !DATA_OE_N || !OUTPUT_DISABLE_N;
   oe_async_a: assert property (!OUTPUT_DISABLE_N |-> DATA_OE_N)
      else $error("bus driven while output disable low");
   rd_drive_a: assert property (rd_ld ##1 run ##1 run |=> on_ok)
      else $error("read data not driven two cycles after load");
   wr_release_a: assert property (wr_ld ##1 run ##1 run |=> DATA_OE_N)
      else $error("bus not released two cycles after write load");
   desel_release_a: assert property (desel ##1 run ##1 run |=> DATA_OE_N)
      else $error("bus not released two cycles after deselect");
   wr_rd_turn_a: assert property (wr_ld ##1 rd_ld ##1 run ##1 run |=> on_ok)
      else $error("read after write lost a cycle");
   adv_read_a: assert property (rd_ld ##1 (run && LOAD_OR_ADVANCE) ##1 run ##1 run |=> on_ok)
      else $error("burst advance gave no read data");
   drain_desel_a: assert property (rd_ld ##1 desel ##1 run ##1 (run && !DATA_OE_N) |=> DATA_OE_N)
      else $error("bus held after pending read finished");
   suspend_hold_a: assert property (CYCLE_SUSPEND_N |=> $stable(DATA_OUT) && $stable(PORT_STALLED))
      else $error("outputs moved while suspended");
endmodule : pbsp_sram_port_asserts

bind pbsp_sram_port pbsp_sram_port_asserts chk (
   .CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR), .CHIP_SELECT_A_N(CHIP_SELECT_A_N),
   .CHIP_SELECT_B(CHIP_SELECT_B), .CHIP_SELECT_C_N(CHIP_SELECT_C_N), .LOAD_OR_ADVANCE(LOAD_OR_ADVANCE),
   .CYCLE_SUSPEND_N(CYCLE_SUSPEND_N), .WRITE_SELECT_N(WRITE_SELECT_N), .LANE_WRITE_N(LANE_WRITE_N),
   .OUTPUT_DISABLE_N(OUTPUT_DISABLE_N), .SLEEP_REQUEST(SLEEP_REQUEST), .DATA_OUT(DATA_OUT),
   .DATA_OE_N(DATA_OE_N), .PORT_STALLED(PORT_STALLED)
);

// file: tb/pbsp_master_model.sv
// Purpose: memory controller side of the data path
// Assumes: bench tells it when to drive write data
// Notes:   a released bus shows the inverse of its last value
`timescale 1ns/1ps
module pbsp_master_model (
   input  wire logic                clk,
   input  wire logic                m_en,
   input  wire pbsp_pkg::pbsp_data_t m_data,
   output pbsp_pkg::pbsp_data_t     din,
   output logic                     sleep_req
);
   pbsp_pkg::pbsp_data_t last;
   assign sleep_req = 1'b0;
   // write data offered at the edge two cycles after its load
   always_comb din = m_en ? m_data : ~last;
   always_ff @(posedge clk) last <= din;
endmodule : pbsp_master_model

// file: tb/pbsp_sram_port_test.sv
// Purpose: self-checking bench of the sram port
// Assumes: inputs change at falling edges
// Notes:   zero step data means the master leaves the bus
`timescale 1ns/1ps
module pbsp_sram_port_test;
   localparam logic [3:0] SEL = 4'h2;
   localparam logic [3:0] DS  = 4'h6;
   localparam logic [3:0] SUS = 4'ha;
   logic CORE_CLK = 0, RST = 1, LOAD_OR_ADVANCE = 0, WRITE_SELECT_N = 1, BURST_ORDER = 0;
   logic CHIP_SELECT_A_N = 1, CHIP_SELECT_B = 1, CHIP_SELECT_C_N = 0, CYCLE_SUSPEND_N = 0;
   logic OUTPUT_DISABLE_N = 1, m_en = 0, DATA_OE_N, PORT_STALLED, sleep;
   logic [3:0] lanes = 4'h0;
   pbsp_pkg::pbsp_addr_t ADDR = '0;
   pbsp_pkg::pbsp_data_t m_data = '0, DATA_IN, DATA_OUT;
   int err_total = 0, comparisons = 0, cyc = 0;
   always #50 CORE_CLK = ~CORE_CLK;
   pbsp_master_model mm (.clk(CORE_CLK), .m_en(m_en), .m_data(m_data), .din(DATA_IN), .sleep_req(sleep));
   pbsp_sram_port uut (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR), .CHIP_SELECT_A_N(CHIP_SELECT_A_N),
      .CHIP_SELECT_B(CHIP_SELECT_B), .CHIP_SELECT_C_N(CHIP_SELECT_C_N), .LOAD_OR_ADVANCE(LOAD_OR_ADVANCE),
      .CYCLE_SUSPEND_N(CYCLE_SUSPEND_N), .WRITE_SELECT_N(WRITE_SELECT_N), .LANE_WRITE_N(lanes),
      .BURST_ORDER(BURST_ORDER), .OUTPUT_DISABLE_N(OUTPUT_DISABLE_N), .SLEEP_REQUEST(sleep),
      .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .PORT_STALLED(PORT_STALLED));
   task test_done;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   always @(posedge CORE_CLK) begin
      cyc++;
      if (cyc > 2000) begin
         err_total++;
         test_done();
      end
   end
   task check(input string what, input pbsp_pkg::pbsp_data_t seen, input pbsp_pkg::pbsp_data_t exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one request slot, then the answer of the slot two back
   task step(input logic adv, input logic wr_n, input logic [3:0] c, input pbsp_pkg::pbsp_addr_t a,
             input pbsp_pkg::pbsp_data_t d, input logic eo, input pbsp_pkg::pbsp_data_t ed);
      @(negedge CORE_CLK);
      {CYCLE_SUSPEND_N, CHIP_SELECT_A_N, CHIP_SELECT_B, CHIP_SELECT_C_N} = c;
      LOAD_OR_ADVANCE = adv;
      WRITE_SELECT_N = wr_n;
      ADDR = a;
      m_data = d;
      m_en = |d;
      @(posedge CORE_CLK);
      #1;
      check("oe", {35'h0, DATA_OE_N}, {35'h0, eo});
      if (!eo) check("rdata", DATA_OUT, ed);
      check("stall", {35'h0, PORT_STALLED}, 36'h0);
   endtask : step
   function pbsp_pkg::pbsp_data_t pat(input pbsp_pkg::pbsp_ofs_t o);
      return 36'h5a0000000 | {34'h0, o};
   endfunction : pat
   task t_turn;
      pbsp_pkg::pbsp_data_t m;
      m = (36'hfedcba987 & 36'hff803fe00) | (36'h0abcdef01 & ~36'hff803fe00);
      step(0, 0, SEL, 18'h10, 0, 1, 0);
      step(0, 1, SEL, 18'h10, 0, 1, 0);
      step(0, 0, SEL, 18'h20, 36'h123456789, 1, 0);
      lanes = 4'h5;
      step(0, 0, SEL, 18'h20, 0, 0, 36'h123456789);
      lanes = 4'hf;
      step(0, 1, SEL, 18'h20, 36'h0abcdef01, 1, 0);
      step(0, 1, DS, 0, 36'hfedcba987, 1, 0);
      step(0, 1, DS, 0, 0, 0, m);
      step(0, 1, DS, 0, 0, 1, 0);
      lanes = 4'h0;
   endtask : t_turn
   task t_burst(input logic ord);
      pbsp_pkg::pbsp_ofs_t o;
      BURST_ORDER = ord;
      repeat (4) step(0, 1, DS, 0, 0, 1, 0);
      for (int i = 0; i < 6; i++) step(i > 0 && i < 4, i > 3, i < 4 ? SEL : DS, 18'h100,
         i > 1 ? pat(2'(i - 2)) : 36'h0, 1, 0);
      for (int i = 0; i < 8; i++) begin
         o = ord ? 2'h1 ^ 2'(i - 2) : 2'h1 + 2'(i - 2);
         step(i > 0 && i < 5, 1, i < 5 ? SEL : DS, 18'h101, 0, !(i > 1 && i < 7), pat(o));
      end
   endtask : t_burst
   task t_deselect(input logic [3:0] c);
      step(0, 1, SEL, 18'h101, 0, 1, 0);
      step(1, 1, SEL, 0, 0, 1, 0);
      step(0, 1, c, 0, 0, 0, pat(2'h1));
      step(1, 1, SEL, 0, 0, 0, pat(2'h2));
      step(0, 1, DS, 0, 0, 1, 0);
      step(0, 1, DS, 0, 0, 1, 0);
   endtask : t_deselect
   task t_suspend;
      step(0, 1, SEL, 18'h10, 0, 1, 0);
      step(0, 0, SUS, 18'h20, 0, 1, 0);
      step(1, 0, SUS, 18'h20, 0, 1, 0);
      step(0, 1, DS, 0, 0, 1, 0);
      step(0, 1, DS, 0, 0, 0, 36'h123456789);
      step(0, 1, DS, 0, 0, 1, 0);
   endtask : t_suspend
   task t_outdis;
      step(0, 1, SEL, 18'h10, 0, 1, 0);
      step(0, 1, DS, 0, 0, 1, 0);
      step(0, 1, DS, 0, 0, 0, 36'h123456789);
      @(negedge CORE_CLK);
      OUTPUT_DISABLE_N = 0;
      #1;
      check("oe_off", {35'h0, DATA_OE_N}, 36'h1);
      @(negedge CORE_CLK);
      OUTPUT_DISABLE_N = 1;
      step(0, 1, DS, 0, 0, 1, 0);
   endtask : t_outdis
   initial begin
      repeat (6) @(negedge CORE_CLK);
      RST = 0;
      #1;
      check("rst_oe", {35'h0, DATA_OE_N}, 36'h1);
      t_turn();
      t_burst(0);
      t_burst(1);
      BURST_ORDER = 0;
      // order passes two flops; let it settle before the next burst
      repeat (2) step(0, 1, DS, 0, 0, 1, 0);
      t_deselect(4'h6);
      t_deselect(4'h0);
      t_deselect(4'h3);
      t_suspend();
      t_outdis();
      test_done();
   end
endmodule : pbsp_sram_port_test
